// File: hdl/ebcr_pkg.sv
/*
 * package of the extended bus configuration block: register offsets,
 * field layout, reset values, bus clock timing and carrier structs.
 * assumes a 32-bit ahb-lite bus with one word per register.
 */
package ebcr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned AW            = 12;
    localparam logic [7:0]  EXT_CFG_IDX   = 8'h3F;
    localparam logic [11:0] EXT_CFG_ADDR  = {2'h0, EXT_CFG_IDX, 2'h0};
    localparam logic [11:0] PRIM_CFG_ADDR = 12'h000;
    localparam logic [11:0] CMD_ADDR      = 12'h004;
    localparam logic [11:0] STAT_ADDR     = 12'h008;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned EXT_MODE_BIT  = 15;
    localparam int unsigned SOFT_RST_BIT  = 0;
    localparam logic [11:0] EXT_CTL_RST   = 12'h000;
    localparam logic [15:0] PRIM_CFG_RST  = 16'h0000;
    localparam logic [15:0] CMD_RST       = 16'h0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    // hclk cycles per half period of the bus clock
    localparam int unsigned BUS_CLK_HALF  = 2;

    typedef struct packed {
        logic [3:0] ext_out_level;
        logic       heartbeat_disable;
        logic       rsv10;
        logic       jabber_timer_disable;
        logic       auto_media;
        logic       rsv7;
        logic       transceiver_loopback;
        logic       rsv5;
        logic       hold_edge_select;
        logic       rsv3;
        logic       compress_on_match;
        logic       compress_on_miss;
        logic       reject_on_match;
    } ebcr_cfg_t;

    typedef struct packed {
        logic addr_valid;
        logic cam_match;
        logic broadcast;
        logic frame_end;
    } ebcr_rx_t;

    typedef struct packed {
        logic soft_reset;
        logic media_tp;
        logic tp_link;
        logic bus_master;
    } ebcr_stat_t;

endpackage

// File: hdl/ebcr_sync.sv
/*
 * two flip-flop synchroniser for a group of level inputs.
 * assumes inputs change slowly against hclk.
 */
`timescale 1ns/100ps
`default_nettype none
module ebcr_sync #(
    parameter int unsigned W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// File: hdl/ebcr_busclk_div.sv
/*
 * divides hclk into the bus clock and gives one-cycle pulses on its
 * rising and falling edges. assumes half >= 1.
 */
`timescale 1ns/100ps
`default_nettype none
module ebcr_busclk_div #(
    parameter int unsigned HALF = ebcr_pkg::BUS_CLK_HALF
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // bus clock and edge pulses
    output var  logic bus_clk,
    output var  logic rise_en,
    output var  logic fall_en
);
    localparam int unsigned CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q   <= '0;
            bus_clk <= 1'b0;
            rise_en <= 1'b0;
            fall_en <= 1'b0;
        end
        else if (cnt_q == LAST)
        begin
            cnt_q   <= '0;
            bus_clk <= ~bus_clk;
            rise_en <= ~bus_clk;
            fall_en <= bus_clk;
        end
        else
        begin
            cnt_q   <= cnt_q + 1'b1;
            rise_en <= 1'b0;
            fall_en <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hdl/ebcr_top.sv
/*
 * extended bus configuration register with its ahb-lite slave and the
 * logic it steers: user outputs, heartbeat, jabber, media selection,
 * loopback, hold timing, packet compress and cam reject.
 * assumes bus_master, hold_req and rx come from logic on hclk; the
 * link, media select and heartbeat inputs are pins.
 */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

// Function
// - hardware reset clears all bits except the four output levels
// - software reset leaves the register untouched
// - as bus master, drive user outputs from bits 15-12
// - user outputs exist only in extended bus mode
// - bit 11 set ignores heartbeat; clear enables heartbeat checking
// - jabber timer runs with bit 9 clear, disabled with it set
// - auto media select prefers twisted pair with good link
// - auto select ignores media select pin; otherwise pin decides
// - bit 6 loops transmit data back in twisted pair transceiver
// - bit 4 clear: hold changes on bus clock falling edge
// - bit 4 set: hold changes half bus clock later, rising edge
// - compress on cam match when bit 2 set, bit 1 clear
// - compress on miss when bit 1 only; never for broadcast
// - both compress bits never set; both clear floats compress
// - bit 0 rejects cam matches, other accept settings unchanged
module ebcr_top #(
    parameter int unsigned BUS_HALF = ebcr_pkg::BUS_CLK_HALF
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    // device logic on hclk
    input  wire logic              bus_master,
    input  wire logic              hold_req,
    input  wire ebcr_pkg::ebcr_rx_t rx,
    // pins
    input  wire logic              tp_link_good_pin,
    input  wire logic              media_select_pin,
    input  wire logic              heartbeat_pin,
    // outputs
    output var  logic [3:0]        ext_user_output,
    output var  logic              ext_user_output_oe,
    output var  logic              heartbeat_seen,
    output var  logic              jabber_timer_en,
    output var  logic              media_tp_sel,
    output var  logic              transceiver_loopback,
    output var  logic              bus_clk,
    output var  logic              hold,
    output var  logic              packet_compress_out,
    output var  logic              packet_compress_out_oe,
    output var  logic              rx_reject,
    output var  logic              soft_reset
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pins_s;
    logic       link_s;
    logic       msel_s;
    logic       hb_s;

    ebcr_sync #(.W(3)) u_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .d     ({tp_link_good_pin, media_select_pin, heartbeat_pin}),
        .q     (pins_s)
    );
    assign link_s = pins_s[2];
    assign msel_s = pins_s[1];
    assign hb_s   = pins_s[0];

    // ------------------------------------------------------------------
    // bus clock
    // ------------------------------------------------------------------
    logic rise_en;
    logic fall_en;

    ebcr_busclk_div #(.HALF(BUS_HALF)) u_div (
        .clk     (hclk),
        .rst_n   (hresetn),
        .bus_clk (bus_clk),
        .rise_en (rise_en),
        .fall_en (fall_en)
    );

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    logic        ap_take;
    logic        dp_wr_q;
    logic [11:0] dp_addr_q;
    logic [3:0]  level_q;
    logic [3:0]  level_d;
    logic [11:0] ctl_q;
    logic [11:0] ctl_d;
    logic [15:0] prim_q;
    logic [15:0] prim_d;
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic [15:0] rd_word;
    ebcr_pkg::ebcr_cfg_t  cfg;
    ebcr_pkg::ebcr_stat_t stat;

    // zero wait states: hsize is not checked, only words are expected
    assign ap_take = hsel & htrans[1] & hready;
    assign cfg     = ebcr_pkg::ebcr_cfg_t'({level_q, ctl_q});
    assign stat    = '{soft_reset: cmd_q[ebcr_pkg::SOFT_RST_BIT],
                       media_tp: media_tp_sel,
                       tp_link: link_s,
                       bus_master: bus_master};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 12'h000;
        end
        else if (hready)
        begin
            dp_wr_q   <= ap_take & hwrite;
            dp_addr_q <= haddr[11:0];
        end
    end

    // next values; reads use them so a read right after a write sees it
    always_comb
    begin
        level_d = level_q;
        ctl_d   = ctl_q;
        prim_d  = prim_q;
        cmd_d   = cmd_q;
        if (dp_wr_q)
        begin
            unique case (dp_addr_q)
                ebcr_pkg::EXT_CFG_ADDR:
                begin
                    level_d = hwdata[15:12];
                    ctl_d   = hwdata[11:0];
                end
                ebcr_pkg::PRIM_CFG_ADDR: prim_d = hwdata[15:0];
                ebcr_pkg::CMD_ADDR:      cmd_d  = hwdata[15:0];
                default:                 ;
            endcase
        end
    end

    // levels have no reset: unknown until written
    always_ff @(posedge hclk)
    begin
        level_q <= level_d;
    end

    // software reset is just a command bit, it never touches ctl_q
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctl_q <= ebcr_pkg::EXT_CTL_RST;
        else
            ctl_q <= ctl_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prim_q <= ebcr_pkg::PRIM_CFG_RST;
            cmd_q  <= ebcr_pkg::CMD_RST;
        end
        else
        begin
            prim_q <= prim_d;
            cmd_q  <= cmd_d;
        end
    end

    always_comb
    begin
        unique case (haddr[11:0])
            ebcr_pkg::EXT_CFG_ADDR:  rd_word = {level_d, ctl_d};
            ebcr_pkg::PRIM_CFG_ADDR: rd_word = prim_d;
            ebcr_pkg::CMD_ADDR:      rd_word = cmd_d;
            ebcr_pkg::STAT_ADDR:     rd_word = {12'h000, stat};
            default:                 rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (ap_take && !hwrite)
            hrdata    <= {16'h0000, rd_word};
    end

    // ------------------------------------------------------------------
    // steered outputs
    // ------------------------------------------------------------------
    logic ext_mode;
    logic hold_edge;

    assign ext_mode  = prim_q[ebcr_pkg::EXT_MODE_BIT];
    assign hold_edge = cfg.hold_edge_select ? rise_en : fall_en;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_user_output    <= 4'h0;
            ext_user_output_oe <= 1'b0;
        end
        else
        begin
            ext_user_output    <= cfg.ext_out_level;
            ext_user_output_oe <= bus_master & ext_mode;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            heartbeat_seen       <= 1'b0;
            jabber_timer_en      <= 1'b0;
            transceiver_loopback <= 1'b0;
            soft_reset           <= 1'b0;
        end
        else
        begin
            heartbeat_seen       <= hb_s & ~cfg.heartbeat_disable;
            jabber_timer_en      <= ~cfg.jabber_timer_disable;
            transceiver_loopback <= cfg.transceiver_loopback;
            soft_reset           <= cmd_q[ebcr_pkg::SOFT_RST_BIT];
        end
    end

    // media: in auto mode link good prefers twisted pair, else attachment unit; otherwise the pin decides
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            media_tp_sel <= 1'b0;
        else if (cfg.auto_media)
            media_tp_sel <= link_s;
        else
            media_tp_sel <= msel_s;
    end

    // hold follows the request only on the chosen bus clock edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hold <= 1'b0;
        else if (hold_edge)
            hold <= hold_req;
    end

    // ------------------------------------------------------------------
    // receive filtering
    // ------------------------------------------------------------------
    logic comp_hit;

    // both mode bits set is illegal and compresses nothing
    always_comb
    begin
        comp_hit = 1'b0;
        if (cfg.compress_on_match && !cfg.compress_on_miss)
            comp_hit = rx.cam_match;
        else if (cfg.compress_on_miss && !cfg.compress_on_match)
            comp_hit = !rx.cam_match && !rx.broadcast;
    end

    // a new address in the same cycle as frame end wins over the clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            packet_compress_out <= 1'b0;
        else if (rx.addr_valid)
            packet_compress_out <= comp_hit;
        else if (rx.frame_end)
            packet_compress_out <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            packet_compress_out_oe <= 1'b0;
            rx_reject              <= 1'b0;
        end
        else
        begin
            packet_compress_out_oe <= cfg.compress_on_match |
                                      cfg.compress_on_miss;
            rx_reject <= rx.addr_valid & rx.cam_match &
                         cfg.reject_on_match;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_reset_ctl_zero: assert property ($rose(hresetn) |-> ctl_q == 12'h000)
        else $error("control bits not zero after reset");

    a_soft_reset_keep: assert property (
        soft_reset && !dp_wr_q |=> $stable(ctl_q))
        else $error("config changed without a write");

    a_ext_out_drive: assert property (
        bus_master && ext_mode |=> ext_user_output_oe &&
        ext_user_output == $past(level_q))
        else $error("user outputs not driven from levels");

    a_ext_out_mode: assert property (!ext_mode |=> !ext_user_output_oe)
        else $error("user outputs driven outside extended mode");

    a_heartbeat_gate: assert property (
        cfg.heartbeat_disable |=> !heartbeat_seen)
        else $error("heartbeat seen while disabled");

    a_jabber_level: assert property (
        $changed(cfg.jabber_timer_disable) |=>
        jabber_timer_en == !$past(cfg.jabber_timer_disable))
        else $error("jabber enable wrong");

    a_media_auto: assert property (
        cfg.auto_media |=> media_tp_sel == $past(link_s))
        else $error("auto media not following link");

    a_media_pin: assert property (
        !cfg.auto_media |=> media_tp_sel == $past(msel_s))
        else $error("media not following pin");

    a_loopback_bit: assert property (
        cfg.transceiver_loopback[*2] |-> transceiver_loopback)
        else $error("loopback not enabled");

    a_hold_edge: assert property (
        $changed(hold) |-> $past(hold_edge))
        else $error("hold changed off the chosen edge");

    a_compress_float: assert property (
        !cfg.compress_on_match && !cfg.compress_on_miss |=>
        !packet_compress_out_oe)
        else $error("compress output driven with both modes off");

    a_compress_bcast: assert property (
        rx.addr_valid && rx.broadcast && !cfg.compress_on_match |=>
        !packet_compress_out)
        else $error("compress asserted for broadcast");

    a_compress_match: assert property (
        rx.addr_valid && rx.cam_match && cfg.compress_on_match &&
        !cfg.compress_on_miss |=> packet_compress_out)
        else $error("compress missing on cam match");

    a_reject_match: assert property (
        rx.addr_valid && rx.cam_match && cfg.reject_on_match |=> rx_reject)
        else $error("cam match not rejected");

    a_readback_cfg: assert property (
        ap_take && !hwrite && haddr[11:0] == ebcr_pkg::EXT_CFG_ADDR &&
        !dp_wr_q |=> hrdata[15:0] === {level_q, ctl_q})
        else $error("read does not return stored value");

    c_auto_media: cover property (cfg.auto_media && $rose(media_tp_sel));
    c_hold_late: cover property (cfg.hold_edge_select && $rose(hold));
    c_compress_miss: cover property (cfg.compress_on_miss &&
                                     $rose(packet_compress_out));
    c_user_out: cover property ($rose(ext_user_output_oe));

endmodule
`default_nettype wire

// File: tb/ebcr_host_model.sv
/*
 * host model: ahb-lite master doing single word transfers.
 * assumes hready is the slave's hreadyout and that every task is
 * entered just after a rising edge of hclk.
 */
`timescale 1ns/100ps
`default_nettype none
module ebcr_host_model (
    // clock
    input  wire logic        hclk,
    // ahb-lite master
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    // ----------------
    // bus cycles
    // ----------------
    initial
    begin
        hsel   = 1'h1;
        haddr  = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize  = 3'h2;
        hwdata = 32'h5A5A5A5A;
    end

    // bounded wait for hready sampled high at a rising edge
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hready !== 1'h1 && n < 64);
        ok = (hready === 1'h1);
    endtask

    // one idle cycle at the end lets stale write data be seen to change
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic ok);
        logic ok_a;
        haddr  <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready(ok_a);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(ok);
        rd = hrdata;
        ok = ok & ok_a;
        hwdata <= ~wd;
        @(posedge hclk);
    endtask
endmodule
`default_nettype wire

// File: tb/test_extended_bus_config_register.sv
/*
 * self-checking bench for ebcr_top: random settings plus reset, soft
 * reset, unmapped read and every compress mode.
 * assumes the host model drives the ahb side of the design.
 */
`timescale 1ns/100ps
`default_nettype none
module test_extended_bus_config_register;
    localparam logic [11:0] CFG = ebcr_pkg::EXT_CFG_ADDR;
    localparam logic [11:0] CMD = ebcr_pkg::CMD_ADDR;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, hold;
    logic [31:0] haddr, hwdata, hrdata, rd, r, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        bus_master, hold_req, tp_link_good_pin, bus_clk;
    logic        media_select_pin, heartbeat_pin, ext_user_output_oe;
    logic [3:0]  ext_user_output;
    logic        heartbeat_seen, jabber_timer_en, media_tp_sel;
    logic        transceiver_loopback, packet_compress_out, soft_reset;
    logic        packet_compress_out_oe, rx_reject;
    ebcr_pkg::ebcr_rx_t  rx;
    ebcr_pkg::ebcr_cfg_t cfg;
    int          fails, check_count, n;

    ebcr_top #(.BUS_HALF(2)) DUT (.*, .hready(hreadyout));
    ebcr_host_model host (.*, .hready(hreadyout));

    always #5 hclk = ~hclk;

    // ----------------
    // helpers
    // ----------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // compress level expected for one received address
    function automatic logic exp_pc(ebcr_pkg::ebcr_cfg_t c, logic m,
                                    logic b);
        if (c.compress_on_match && !c.compress_on_miss)
            return m;
        if (c.compress_on_miss && !c.compress_on_match)
            return !m && !b;
        return 1'h0;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        logic ok;
        host.xfer(w, a, wd, rd, ok);
        if (!ok)
        begin
            fails++;
            $display("timeout on bus at t=%0t", $time);
            conclude();
        end
    endtask

    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        hclk = 1'h0;
        hresetn = 1'h0;
        {bus_master, hold_req, tp_link_good_pin} = 3'h0;
        {media_select_pin, heartbeat_pin} = 2'h0;
        rx = 4'h0;
        seed = 32'h8A149271;
        fails = 0;
        check_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, CFG, 32'h0);
        chk(rd & 32'h00000FFF, 32'h0);
        chk(jabber_timer_en, 32'h1);
        chk(packet_compress_out_oe, 32'h0);
        bus(1'h0, 12'h0F0, 32'h0);
        chk(rd, 32'h0);
        chk(hresp, 32'h0);
        chk(hreadyout, 32'h1);
        $display("test reset_and_unmapped done");
        for (int i = 0; i < 30; i++)
        begin
            r = rnd();
            cfg = r[31:16];
            {cfg.rsv10, cfg.rsv7, cfg.rsv5, cfg.rsv3} = 4'h0;
            cfg.compress_on_match = (i % 3 == 1);
            cfg.compress_on_miss = (i % 3 == 2);
            bus(1'h1, CMD, 32'h1);
            bus(1'h1, ebcr_pkg::PRIM_CFG_ADDR, {16'h0, r[0], 15'h0});
            bus(1'h1, CFG, {16'h0, cfg});
            bus(1'h0, CFG, 32'h0);
            chk(rd, {16'h0, cfg});
            bus(1'h1, CMD, 32'h0);
            r[5] = r[5] | cfg.transceiver_loopback;
            bus_master <= r[1];
            tp_link_good_pin <= r[2];
            media_select_pin <= r[3];
            heartbeat_pin <= r[4];
            hold_req <= ~hold_req;
            rx <= {1'h1, r[5], r[6], 1'h0};
            @(posedge hclk);
            rx <= 4'h0;
            #1;
            chk(packet_compress_out_oe, cfg[2] | cfg[1]);
            if (packet_compress_out_oe === 1'h1)
                chk(packet_compress_out, exp_pc(cfg, r[5], r[6]));
            chk(rx_reject, r[5] & cfg.reject_on_match);
            n = 0;
            while (hold !== hold_req && n < 20)
            begin
                @(posedge hclk);
                #1;
                n++;
            end
            chk(hold, hold_req);
            if (hold !== hold_req)
                conclude();
            chk(bus_clk, cfg.hold_edge_select);
            @(posedge hclk);
            rx <= 4'h1;
            @(posedge hclk);
            rx <= 4'h0;
            repeat (4) @(posedge hclk);
            #1;
            chk(packet_compress_out, 32'h0);
            chk(ext_user_output_oe, r[1] & r[0]);
            chk(ext_user_output, cfg.ext_out_level);
            chk(heartbeat_seen, r[4] & ~cfg.heartbeat_disable);
            chk(jabber_timer_en, !cfg.jabber_timer_disable);
            chk(media_tp_sel, cfg.auto_media ? r[2] : r[3]);
            chk(transceiver_loopback, cfg.transceiver_loopback);
            @(posedge hclk);
        end
        $display("test random_config done");
        bus(1'h1, CMD, 32'h1);
        @(posedge hclk);
        #1;
        chk(soft_reset, 32'h1);
        @(posedge hclk);
        bus(1'h0, CFG, 32'h0);
        chk(rd, {16'h0, cfg});
        bus(1'h0, ebcr_pkg::STAT_ADDR, 32'h0);
        chk(rd, {28'h0, 1'h1, (cfg.auto_media ? r[2] : r[3]), r[2], r[1]});
        $display("test soft_reset done");
        bus(1'h1, CFG, 32'h0000FB55);
        hresetn <= 1'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        bus(1'h0, CFG, 32'h0);
        chk(rd & 32'h00000FFF, 32'h0);
        $display("test hard_reset done");
        conclude();
    end
endmodule
`default_nettype wire
